// [shared/flash_option_pkg.sv]
// constants for the flash option settings register
package flash_option_pkg;

    localparam logic [15:0] OPT_OFFSET    = 16'h0000;
    localparam logic [15:0] OPT_RESET     = 16'h00FE;
    localparam logic [15:0] OPT_RSVD_MASK = 16'hD8C8;

    // field positions in flash_option_settings
    localparam int BF_BIT    = 13;
    localparam int MECF_BIT  = 10;
    localparam int CHK_MSB   = 9;
    localparam int CHK_LSB   = 8;
    localparam int PW_BIT    = 5;
    localparam int PROT_BIT  = 4;
    localparam int SSW_BIT   = 2;
    localparam int SSC_MSB   = 1;
    localparam int SSC_LSB   = 0;

    // field positions in the nonvolatile boot option byte
    localparam int NVB_BF_BIT   = 5;
    localparam int NVB_MECF_BIT = 2;
    localparam int NVB_CHK_MSB  = 1;
    localparam int NVB_CHK_LSB  = 0;

    // checksum select codes
    localparam logic [1:0] CHK_NONE_A = 2'h0;
    localparam logic [1:0] CHK_POR    = 2'h1;
    localparam logic [1:0] CHK_ANY    = 2'h2;
    localparam logic [1:0] CHK_NONE_B = 2'h3;

    // security state codes
    localparam logic [1:0] SSC_SECURE = 2'h2;
    localparam logic [1:0] SSC_OPEN   = 2'h3;

    typedef enum logic [0:0] {
        ST_LOAD,
        ST_RUN
    } load_state_e;

endpackage

// [rtl/flash_option_decode.sv]
// decode of option fields into flash controller controls
module flash_option_decode
    import flash_option_pkg::*;
(
    input  wire logic [1:0] checksumSelect,
    input  wire logic       lastResetPor,
    input  wire logic       eraseOnCrcFailN,
    input  wire logic       writeProtectN,
    input  wire logic [1:0] securityStateCode,
    output logic            checksumRun,
    output logic            eraseArm,
    output logic            progEraseInhibit,
    output logic            secure
);

    always_comb begin
        // see R09
        case (checksumSelect)
            CHK_POR:    checksumRun = lastResetPor;
            CHK_ANY:    checksumRun = 1'b1;
            default:    checksumRun = 1'b0;
        endcase
        // see R07
        eraseArm = ((checksumSelect == CHK_POR) || (checksumSelect == CHK_ANY))
                   && !eraseOnCrcFailN;
        progEraseInhibit = !writeProtectN;                 // see R11
        secure = (securityStateCode == SSC_SECURE);        // see R13
    end

endmodule

// [rtl/flash_option_register.sv]
// flash option settings register with nonvolatile reload and write gating
//
// Behaviour
// R01 - option register at offset 0x0000, sixteen bits, reset value 0x00FE.
// R02 - each reset reloads low byte from last flash byte, losing software changes.
// R03 - only supervisor accesses reach the register; user accesses are refused.
// R04 - software writes zeros to reserved bits 15:14 and 12.
// R05 - bit 13 boot-to-flash is read/write, power-up value is inverted boot byte bit 5.
// R06 - bit 10 erase-on-crc-fail (active low) loads from boot byte bit 2 at power-up.
// R07 - checksum 01/10 with crc failure erases user flash when bit 10 is zero.
// R08 - checksum select loads from boot byte only on power-on; writes govern later resets.
// R09 - checksum select: 00/11 none, 01 power-on only, 10 any reset.
// R10 - write-protect bit changes only while protect-writable bit 5 is one.
// R11 - write-protect low inhibits program and erase; high leaves array open.
// R12 - security code changes only while security-writable bit 2 is one.
// R13 - security code 10 is secure; flash hidden from unsecure sources then.
// R14 - each reset reloads security code from bits 1:0 of last flash byte.
// R15 - security code holds 10 during reset, then reloads right after release.
// R16 - supervisor may write 11 to clear security until next reset.
// R17 - reserved bits 11, 7:6 and 3 read zero and ignore writes; a read in the load cycle after reset returns bits 7:6 and 3 as one.
module flash_option_register
    import flash_option_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        porRst_n,
    input  wire logic        clkEn,
    input  wire logic        regSel,
    input  wire logic        regWr,
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        supervisor,
    input  wire logic [7:0]  nv_option_low_byte,
    input  wire logic [7:0]  nv_boot_option_byte,
    input  wire logic        crcDone,
    input  wire logic        crcPass,
    output logic [15:0]      regRdata,
    output logic             regAck,
    output logic             accessError,
    output logic             loadDone,
    output logic             checksumRequired,
    output logic             eraseUserFlash,
    output logic             progEraseInhibit,
    output logic             flashSecure
);

    load_state_e loadState_r;
    logic        porSeen_r;
    logic        lastResetPor_r;
    logic        boot_to_flash_flag_r;
    logic        erase_on_crc_fail_n_r;
    logic [1:0]  checksum_select_r;
    logic        protect_bit_writable_r;
    logic        write_protect_n_r;
    logic        security_code_writable_r;
    logic [1:0]  security_state_code_r;
    logic [15:0] flash_option_settings;
    logic        hit;
    logic        swWrite;
    logic        running;
    logic        decChecksum;
    logic        decEraseArm;
    logic        decInhibit;
    logic        decSecure;

    always_comb begin
        flash_option_settings = 16'h0000;                  // see R17
        if (!running) begin
            flash_option_settings = OPT_RESET & OPT_RSVD_MASK;  // see R01
        end
        flash_option_settings[BF_BIT] = boot_to_flash_flag_r;
        flash_option_settings[MECF_BIT] = erase_on_crc_fail_n_r;
        flash_option_settings[CHK_MSB:CHK_LSB] = checksum_select_r;
        flash_option_settings[PW_BIT] = protect_bit_writable_r;
        flash_option_settings[PROT_BIT] = write_protect_n_r;
        flash_option_settings[SSW_BIT] = security_code_writable_r;
        flash_option_settings[SSC_MSB:SSC_LSB] = security_state_code_r;
    end

    assign hit     = regSel && supervisor && (regAddr == OPT_OFFSET);   // see R03
    assign running = (loadState_r == ST_RUN);
    assign swWrite = hit && regWr && running;

    // reload sequencing after reset release
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            loadState_r <= ST_LOAD;
        end else if (clkEn) begin
            loadState_r <= ST_RUN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!porRst_n) begin
            porSeen_r      <= 1'b1;
            lastResetPor_r <= 1'b1;
        end else if (clkEn && rst_n && !running) begin
            porSeen_r      <= 1'b0;
            lastResetPor_r <= porSeen_r;
        end
    end

    // high byte fields survive non power-on resets
    always_ff @(posedge clk_sys) begin
        if (!porRst_n) begin
            boot_to_flash_flag_r  <= OPT_RESET[BF_BIT];
            erase_on_crc_fail_n_r <= OPT_RESET[MECF_BIT];
            checksum_select_r     <= OPT_RESET[CHK_MSB:CHK_LSB];
        end else if (clkEn && rst_n) begin
            if (!running && porSeen_r) begin
                boot_to_flash_flag_r  <= !nv_boot_option_byte[NVB_BF_BIT];      // see R05
                erase_on_crc_fail_n_r <= nv_boot_option_byte[NVB_MECF_BIT];     // see R06
                checksum_select_r     <= nv_boot_option_byte[NVB_CHK_MSB:NVB_CHK_LSB]; // see R08
            end else if (swWrite) begin
                boot_to_flash_flag_r  <= regWdata[BF_BIT];
                erase_on_crc_fail_n_r <= regWdata[MECF_BIT];
                checksum_select_r     <= regWdata[CHK_MSB:CHK_LSB];         // see R08
            end
        end
    end

    // low byte fields, reloaded on every reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            protect_bit_writable_r   <= OPT_RESET[PW_BIT];                  // see R01
            write_protect_n_r        <= OPT_RESET[PROT_BIT];
            security_code_writable_r <= OPT_RESET[SSW_BIT];
            security_state_code_r    <= SSC_SECURE;                         // see R15
        end else if (clkEn) begin
            if (!running) begin
                protect_bit_writable_r   <= nv_option_low_byte[PW_BIT];     // see R02
                write_protect_n_r        <= nv_option_low_byte[PROT_BIT];
                security_code_writable_r <= nv_option_low_byte[SSW_BIT];
                security_state_code_r    <= nv_option_low_byte[SSC_MSB:SSC_LSB]; // see R14
            end else if (swWrite) begin
                protect_bit_writable_r   <= regWdata[PW_BIT];
                security_code_writable_r <= regWdata[SSW_BIT];
                if (protect_bit_writable_r) begin                           // see R10
                    write_protect_n_r <= regWdata[PROT_BIT];
                end
                if (security_code_writable_r) begin                         // see R12 R16
                    security_state_code_r <= regWdata[SSC_MSB:SSC_LSB];
                end
            end
        end
    end

    // register bus answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdata    <= 16'h0000;
            regAck      <= 1'b0;
            accessError <= 1'b0;
        end else if (clkEn) begin
            regAck      <= regSel;
            accessError <= regSel && !hit;                                  // see R03
            regRdata    <= (hit && !regWr) ? flash_option_settings : 16'h0000;
        end
    end

    flash_option_decode u_decode (
        .checksumSelect    (checksum_select_r),
        .lastResetPor      (lastResetPor_r),
        .eraseOnCrcFailN   (erase_on_crc_fail_n_r),
        .writeProtectN     (write_protect_n_r),
        .securityStateCode (security_state_code_r),
        .checksumRun       (decChecksum),
        .eraseArm          (decEraseArm),
        .progEraseInhibit  (decInhibit),
        .secure            (decSecure)
    );

    // controls toward the flash controller
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            loadDone         <= 1'b0;
            checksumRequired <= 1'b0;
            eraseUserFlash   <= 1'b0;
            progEraseInhibit <= 1'b0;
            flashSecure      <= 1'b1;
        end else if (clkEn) begin
            loadDone         <= running;
            checksumRequired <= running && decChecksum;                     // see R09
            eraseUserFlash   <= running && crcDone && !crcPass && decEraseArm; // see R07
            progEraseInhibit <= decInhibit;                                 // see R11
            flashSecure      <= decSecure;                                  // see R13
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_reset_value: assert property (disable iff (1'b0) // see R01
        !rst_n && !porRst_n |=> flash_option_settings == OPT_RESET)
        else $error("option register not at reset value");
    chk_secure_reset: assert property (disable iff (1'b0) // see R15
        !rst_n |=> security_state_code_r == SSC_SECURE && flashSecure)
        else $error("security code not secure during reset");
    chk_low_reload: assert property (!running && clkEn |=> // see R02 R14
        flash_option_settings[7:0] == ($past(nv_option_low_byte) & ~OPT_RSVD_MASK[7:0])
        && running)
        else $error("low byte not reloaded after reset");
    chk_boot_power: assert property (!running && clkEn && porSeen_r |=> // see R05 R06
        boot_to_flash_flag_r == !$past(nv_boot_option_byte[NVB_BF_BIT])
        && erase_on_crc_fail_n_r == $past(nv_boot_option_byte[NVB_MECF_BIT])
        && checksum_select_r == $past(nv_boot_option_byte[NVB_CHK_MSB:NVB_CHK_LSB]))
        else $error("boot byte fields not loaded on power-on");
    chk_checksum_keep: assert property (porRst_n && !running && clkEn && !porSeen_r // see R08
        |=> $stable(checksum_select_r) && $stable(boot_to_flash_flag_r))
        else $error("checksum select changed on warm reset");
    chk_protect_gate: assert property (porRst_n && swWrite && clkEn // see R10
        && !protect_bit_writable_r |=> $stable(write_protect_n_r))
        else $error("protect bit written while locked");
    chk_security_gate: assert property (swWrite && clkEn // see R12 R13
        && security_code_writable_r
        |=> security_state_code_r == $past(regWdata[SSC_MSB:SSC_LSB])
        ##1 (!$past(clkEn)
             || flashSecure == ($past(security_state_code_r) == SSC_SECURE)))
        else $error("security code write or decode wrong");
    chk_security_lock: assert property (swWrite && clkEn && !security_code_writable_r // see R12
        |=> $stable(security_state_code_r))
        else $error("security code written while locked");
    chk_user_block: assert property (porRst_n && regSel && !supervisor && clkEn // see R03
        |=> $stable(flash_option_settings) && accessError && regRdata == 16'h0000)
        else $error("user access reached option register");
    chk_inhibit_out: assert property (clkEn // see R11
        |=> progEraseInhibit == !$past(write_protect_n_r))
        else $error("inhibit does not follow write protect");
    chk_erase_decision: assert property (running && clkEn && crcDone && !crcPass // see R07
        && (checksum_select_r == CHK_POR || checksum_select_r == CHK_ANY)
        |=> eraseUserFlash == !$past(erase_on_crc_fail_n_r))
        else $error("erase decision on crc failure wrong");
    chk_checksum_map: assert property (running && clkEn |=> checksumRequired == // see R09
        ($past(checksum_select_r) == CHK_ANY
         || ($past(checksum_select_r) == CHK_POR && $past(lastResetPor_r))))
        else $error("checksum requirement decode wrong");
    chk_reserved_zero: assert property (regAck // see R17
        |-> (regRdata & OPT_RSVD_MASK) == 16'h0000)
        else $error("reserved bits read nonzero");

    cov_unsecure: cover property (swWrite && clkEn && security_code_writable_r
        && regWdata[SSC_MSB:SSC_LSB] == SSC_OPEN);
    cov_erase: cover property (eraseUserFlash);
    cov_warm_reload: cover property (!running && clkEn && !porSeen_r);
    cov_user_refused: cover property (regSel && !supervisor && clkEn);

endmodule

// [bench/flash_option_register_tb.sv]
// self-checking bench for the flash option settings register
module flash_option_register_tb import flash_option_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, rst_n, porRst_n, clkEn, regSel, regWr, supervisor;
    logic        crcDone, crcPass, regAck, accessError, loadDone;
    logic        checksumRequired, eraseUserFlash, progEraseInhibit, flashSecure;
    logic        lastPor;
    logic [15:0] regAddr, regWdata, regRdata, mdl;
    logic [7:0]  nvLow, nvBoot;
    logic [16:0] expQ[$];
    logic [16:0] got;
    int          err_total, total_checks;
    localparam logic [15:0] WTBL[7] = '{16'h0000, 16'h0013, 16'h0024, 16'h2FFF,
                                        16'h0026, 16'h0002, 16'h0023};

    flash_option_register dut (.clk_sys(clk_sys), .rst_n(rst_n), .porRst_n(porRst_n),
        .clkEn(clkEn), .regSel(regSel), .regWr(regWr), .regAddr(regAddr),
        .regWdata(regWdata), .supervisor(supervisor), .nv_option_low_byte(nvLow),
        .nv_boot_option_byte(nvBoot), .crcDone(crcDone), .crcPass(crcPass),
        .regRdata(regRdata), .regAck(regAck), .accessError(accessError),
        .loadDone(loadDone), .checksumRequired(checksumRequired),
        .eraseUserFlash(eraseUserFlash), .progEraseInhibit(progEraseInhibit),
        .flashSecure(flashSecure));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(string what, logic [16:0] exp, logic [16:0] act);
        total_checks++;
        if (exp !== act) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, act);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic acc(logic wr, logic [15:0] addr, logic [15:0] d, logic sup);
        logic        ok;
        logic [15:0] wm;
        @(negedge clk_sys);
        ok = sup && addr == OPT_OFFSET;
        {regSel, regWr, regAddr, regWdata, supervisor} <= {1'b1, wr, addr, d, sup};
        expQ.push_back({!ok, (ok && !wr) ? mdl : 16'h0000});
        wm = 16'h2724 | (mdl[5] ? 16'h0010 : 16'h0000) | (mdl[2] ? 16'h0003 : 16'h0000);
        if (ok && wr) mdl = (mdl & ~wm) | (d & wm);
    endtask

    task automatic idle(int n);
        repeat (n) begin
            @(negedge clk_sys);
            regSel <= 1'b0;
        end
    endtask

    task automatic rd;
        acc(1'b0, OPT_OFFSET, 16'h0000, 1'b1);
    endtask

    task automatic wr(logic [15:0] d);
        acc(1'b1, OPT_OFFSET, d, 1'b1);
    endtask

    task automatic stat;
        idle(2);
        check("inhibit", !mdl[4], progEraseInhibit);
        check("secure", mdl[1:0] == 2'b10, flashSecure);
    endtask

    task automatic crc(logic pass);
        logic exp;
        exp = !pass && !mdl[10] && (mdl[9:8] == 2'b01 || mdl[9:8] == 2'b10);
        @(negedge clk_sys);
        crcDone <= 1'b1;
        crcPass <= pass;
        @(negedge clk_sys);
        crcDone <= 1'b0;
        check("erase", exp, eraseUserFlash);
        check("checksum", mdl[9:8] == 2'b10 || (mdl[9:8] == 2'b01 && lastPor), checksumRequired);
    endtask

    task automatic doReset(logic por, int n, logic [7:0] lo, logic [7:0] bo);
        int k;
        @(negedge clk_sys);
        rst_n <= 1'b0;
        porRst_n <= !por;
        regSel <= 1'b0;
        repeat (n) @(negedge clk_sys);
        check("secureInReset", 1'b1, flashSecure);
        check("rdataInReset", 17'h0, {regAck, regRdata});
        check("loadInReset", 1'b0, loadDone);
        nvLow <= lo;
        nvBoot <= bo;
        rst_n <= 1'b1;
        porRst_n <= 1'b1;
        lastPor = por;
        mdl[7:0] = lo & 8'h37;
        if (por) mdl[15:8] = {2'b00, !bo[5], 2'b00, bo[2], bo[1:0]};
        k = 0;
        while (loadDone !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        check("loadCycles", 17'h2, 17'(k));
        if (k >= 20) begin
            check("loadDone", 1'b1, loadDone);
            results();
        end
    endtask

    always @(negedge clk_sys) begin
        if (regAck === 1'b1) begin
            if (expQ.size() == 0) check("ack", 17'h0, 17'h1FFFF);
            else begin
                got = expQ.pop_front();
                check("access", got, {accessError, regRdata});
            end
        end
    end

    initial begin
        {rst_n, porRst_n, clkEn, regSel, regWr, supervisor, crcDone, crcPass} = 8'h20;
        {regAddr, regWdata, nvLow, nvBoot, mdl} = '0;
        err_total = 0;
        total_checks = 0;
        void'($urandom(32'hfe2e));
        doReset(1'b1, 16, 8'($urandom), 8'($urandom));
        rd();
        stat();
        $display("test power-on load done");
        acc(1'b0, OPT_OFFSET, 16'h0000, 1'b0);
        acc(1'b1, OPT_OFFSET, 16'hFFFF, 1'b0);
        acc(1'b0, 16'h0002, 16'h0000, 1'b1);
        acc(1'b1, 16'h0002, 16'h0000, 1'b1);
        rd();
        idle(1);
        $display("test refused access done");
        foreach (WTBL[i]) begin
            wr(WTBL[i]);
            rd();
            stat();
        end
        repeat (8) begin
            wr(16'($urandom) & 16'h2FFF);
            rd();
            stat();
        end
        $display("test write gating done");
        for (int s = 0; s < 8; s++) begin
            wr((mdl & 16'hF8FF) | {5'h00, 3'(s), 8'h00});
            stat();
            crc(1'b0);
        end
        wr((mdl & 16'hF8FF) | 16'h0100);
        stat();
        crc(1'b1);
        $display("test crc decode done");
        @(negedge clk_sys);
        clkEn <= 1'b0;
        rd();
        repeat (2) begin
            @(negedge clk_sys);
            check("frozenAck", 1'b0, regAck);
        end
        clkEn <= 1'b1;
        idle(2);
        $display("test clock enable done");
        wr(16'h0024);
        wr(16'h0137);
        doReset(1'b0, 4, 8'($urandom), 8'($urandom));
        rd();
        stat();
        crc(1'b0);
        wr((mdl & 16'hFCFF) | 16'h0200);
        stat();
        crc(1'b0);
        $display("test warm reset done");
        idle(3);
        check("queue", 17'h0, 17'(expQ.size()));
        results();
    end
endmodule
